// *** rtl/bhsb_ctrl.sv ***
// bhsb_ctrl: hall commutated drive with speed loop, bus sensing and brake
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
// Summary of operation
// - partner output is inverted phase, same channel
// - pwm frequency in hertz, dead time in ns
// - proportional gain is signed 9.15
// - integral gain is signed 9.15
// - ramp full range in programmed milliseconds
// - speed from revolution or sector period
// - scale by range, pole pairs; minimum speed
// - brake either on/off or soft pwm
// - brake active level follows host setting
// - brake fully on above upper threshold
// - brake off below lower threshold
// - converter trigger polarity host selected
// - sample read at window end, microseconds
// - results come from queue of 16-bit words
// - left align sample by 8, 10, 12, 16
// - bus sample at host byte offset
// - low pass bus samples, time constant us
// - enable starts pwm, commutation, speed loop
// - open or closed speed loop on enable
// - soft brake duty linear between thresholds
// - sensing synced to period, brake every 16th
// - disable stops pwm, commutation, speed loop
module bhsb_ctrl
  import bhsb_pkg::*;
#(
  parameter int QDEPTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] hall_in,
  input wire logic q_we,
  input wire logic [$clog2(QDEPTH)-1:0] q_addr,
  input wire logic [15:0] q_wdata,
  output logic [2:0] phase_out,
  output logic [2:0] phase_pair_out,
  output logic brake_out,
  output logic adc_trig_out
);
  localparam int QAW = $clog2(QDEPTH);

  // refuse queue depths the byte offset cannot index
  if (QDEPTH < 2 || QDEPTH > 128 || (QDEPTH & (QDEPTH - 1)) != 0) begin : g_chk
    $error("QDEPTH must be a power of two from 2 to 128");
  end

  bhsb_state_t st_ff, nxt_st;
  logic [15:0] q_mem [QDEPTH];

  // byte lane merge of a write into a stored word
  function automatic logic [31:0] bmerge(input logic [31:0] o,
                                         input logic [31:0] d,
                                         input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      bmerge[8*i +: 8] = s[i] ? d[8*i +: 8] : o[8*i +: 8];
    end
  endfunction : bmerge

  // clamp a signed value into the unsigned speed/duty range
  function automatic logic [14:0] sat15(input logic signed [40:0] v);
    if (v < 0) begin
      sat15 = 15'h0;
    end else if (v > $signed({26'h0, SPD_FULL})) begin
      sat15 = SPD_FULL;
    end else begin
      sat15 = v[14:0];
    end
  endfunction : sat15

  // hall code to {sector, pwm phase, low phase}, phase a is bit 0
  function automatic logic [8:0] comm(input logic [2:0] h);
    case (h)
      3'b100: comm = {3'd0, 3'b001, 3'b010};
      3'b110: comm = {3'd1, 3'b001, 3'b100};
      3'b010: comm = {3'd2, 3'b010, 3'b100};
      3'b011: comm = {3'd3, 3'b010, 3'b001};
      3'b001: comm = {3'd4, 3'b100, 3'b001};
      3'b101: comm = {3'd5, 3'b100, 3'b010};
      default: comm = {3'd7, 3'b000, 3'b000};
    endcase
  endfunction : comm

  // configuration fields
  logic [31:0] ctrl;
  logic en, olp, cpl, secsel, bsoft, bhi, thi;
  logic [15:0] range;
  logic [7:0] ppairs, bon, boff;
  logic [23:0] nom;
  assign ctrl = st_ff.w[W_CTRL];
  assign en = ctrl[C_EN];
  assign olp = ctrl[C_OPEN];
  assign cpl = ctrl[C_CPL];
  assign secsel = ctrl[C_SEC];
  assign bsoft = ctrl[C_BSOFT];
  assign bhi = ctrl[C_BHI];
  assign thi = ctrl[C_THI];
  assign range = st_ff.w[W_SPD][15:0];
  assign ppairs = st_ff.w[W_SPD][23:16];
  assign bon = st_ff.w[W_BTHR][7:0];
  assign boff = st_ff.w[W_BTHR][15:8];
  assign nom = st_ff.w[W_NOM][23:0];

  // handshake outputs
  assign s_axi_awready = !st_ff.aw_ok && !st_ff.bvalid;
  assign s_axi_wready = !st_ff.w_ok && !st_ff.bvalid;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rresp = st_ff.rresp;
  assign s_axi_rdata = st_ff.rdata;
  assign phase_out = st_ff.ph;
  assign phase_pair_out = st_ff.pr;
  assign brake_out = st_ff.brk;
  assign adc_trig_out = st_ff.trg;

  // period accumulator: wraps at the clock rate, so it advances in hertz
  logic [25:0] acc_sum;
  logic pstart, praw, ddone, sctick;
  assign acc_sum = st_ff.acc + {1'b0, st_ff.w[W_FREQ][24:0]};
  assign pstart = acc_sum >= 26'(CLK_HZ);
  assign praw = en && ({st_ff.acc, 15'h0} < 41'(st_ff.duty) * 41'(CLK_HZ));
  assign ddone = st_ff.dns >= {1'b0, st_ff.w[W_DEAD][15:0]};
  assign sctick = pstart && (st_ff.sccnt + 8'h1 >= st_ff.w[W_SCDIV][7:0]);

  // hall timing and speed divider operands
  logic [8:0] cm;
  logic hchg;
  logic [26:0] per;
  logic [DW-1:0] den;
  assign cm = comm(hall_in);
  assign hchg = hall_in != st_ff.hprev;
  assign per = secsel ? 27'(st_ff.hcnt) * 27'd6 :
    27'(st_ff.hist[0]) + 27'(st_ff.hist[1]) + 27'(st_ff.hist[2]) +
    27'(st_ff.hist[3]) + 27'(st_ff.hist[4]) + 27'(st_ff.hcnt);
  assign den = DW'(per) * DW'(ppairs) * DW'(range);

  // speed loop error
  logic signed [16:0] err;
  logic signed [23:0] kp, ki;
  logic [35:0] rns;
  assign err = $signed({2'b0, st_ff.ramp}) - $signed({2'b0, st_ff.meas});
  assign kp = st_ff.w[W_KP][23:0];
  assign ki = st_ff.w[W_KI][23:0];
  assign rns = 36'(st_ff.w[W_RAMP][15:0]) * 36'(NS_PER_MS);

  // sensing window, alignment and filter limits
  logic [33:0] wlim, flim;
  logic wend;
  logic [15:0] qraw;
  logic [23:0] xal;
  logic signed [24:0] fdif;
  assign wlim = 34'(st_ff.w[W_SWIN][23:0]) * 34'(NS_PER_US);
  assign flim = 34'(st_ff.w[W_FILT][23:0]) * 34'(NS_PER_US);
  assign wend = st_ff.wns >= wlim;
  assign qraw = q_mem[st_ff.w[W_QOFF][QAW:1]];
  always_comb begin
    case (ctrl[C_SH +: 2])
      2'd0: xal = {qraw, 8'h0};
      2'd1: xal = {qraw[13:0], 10'h0};
      2'd2: xal = {qraw[11:0], 12'h0};
      default: xal = {qraw[7:0], 16'h0};
    endcase
  end
  assign fdif = $signed({1'b0, st_ff.x}) - $signed({1'b0, st_ff.y});

  // brake thresholds as percent of nominal bus code
  logic [31:0] v100, von, voff;
  logic over, under, bcmp;
  assign v100 = 32'(st_ff.vb) * 32'(PCT);
  assign von = 32'(nom) * 32'(bon);
  assign voff = 32'(nom) * 32'(boff);
  assign over = v100 > von;
  assign under = v100 < voff;
  assign bcmp = 64'(v100 - voff) * 64'(CLK_HZ) >
                64'(st_ff.acc) * 64'(nom) * 64'(8'(bon - boff));

  // next state of the whole block
  always_comb begin
    logic [DW-1:0] t;
    logic [DW-1:0] q;
    logic signed [40:0] pt;
    logic signed [40:0] it;
    logic bn;
    nxt_st = st_ff;
    t = '0;
    q = '0;
    pt = '0;
    it = '0;
    bn = 1'b0;
    // register bus: address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.aw_ok = 1'b1;
      nxt_st.awi = s_axi_awaddr[7:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.w_ok = 1'b1;
      nxt_st.wd = s_axi_wdata;
      nxt_st.ws = s_axi_wstrb;
    end
    if (st_ff.aw_ok && st_ff.w_ok) begin
      nxt_st.aw_ok = 1'b0;
      nxt_st.w_ok = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = st_ff.awi <= 6'(W_DUTY) ? RESP_OKAY : RESP_SLVERR;
      if (st_ff.awi < 6'(NCFG)) begin
        nxt_st.w[st_ff.awi] = bmerge(st_ff.w[st_ff.awi], st_ff.wd, st_ff.ws);
      end
    end else if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = RESP_OKAY;
      if (s_axi_araddr[7:2] < 6'(NCFG)) begin
        nxt_st.rdata = st_ff.w[s_axi_araddr[7:2]];
      end else if (s_axi_araddr[7:2] == 6'(W_STAT)) begin
        nxt_st.rdata = {1'b0, st_ff.meas, 7'h0, en, 5'h0, st_ff.sec};
      end else if (s_axi_araddr[7:2] == 6'(W_BUSV)) begin
        nxt_st.rdata = {8'h0, st_ff.y};
      end else if (s_axi_araddr[7:2] == 6'(W_DUTY)) begin
        nxt_st.rdata = {17'h0, st_ff.duty};
      end else begin
        nxt_st.rdata = 32'h0;
        nxt_st.rresp = RESP_SLVERR;
      end
    end else if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    // pwm timebase and dead time counter
    nxt_st.acc = pstart ? acc_sum - 26'(CLK_HZ) : acc_sum;
    nxt_st.raw = praw;
    if (praw != st_ff.raw) begin
      nxt_st.dns = 17'h0;
    end else if (!ddone) begin
      nxt_st.dns = st_ff.dns + 17'(CLK_NS);
    end
    // phase outputs, partner is the inverted pwm with dead time
    if (en) begin
      nxt_st.ph = cm[5:3] & {3{st_ff.raw && ddone}};
      nxt_st.pr = cpl ? (cm[5:3] & {3{!st_ff.raw && ddone}}) | cm[2:0] :
                  3'h0;
    end else begin
      nxt_st.ph = 3'h0;
      nxt_st.pr = 3'h0;
    end
    // hall period capture
    nxt_st.hprev = hall_in;
    nxt_st.sec = cm[8:6];
    if (hchg) begin
      nxt_st.hcnt = 24'h0;
      nxt_st.hist = {st_ff.hist[3:0], st_ff.hcnt};
    end else if (st_ff.hcnt != 24'hffffff) begin
      nxt_st.hcnt = st_ff.hcnt + 24'h1;
    end else begin
      nxt_st.meas = 15'h0;
    end
    // restoring divider: speed = scale / (period * pole pairs * range)
    if (hchg) begin
      nxt_st.dbusy = 1'b1;
      nxt_st.dcnt = 6'(DW);
      nxt_st.drem = '0;
      nxt_st.dquo = SPD_NUM;
      nxt_st.dden = den;
    end else if (st_ff.dbusy) begin
      t = {st_ff.drem[DW-2:0], st_ff.dquo[DW-1]};
      q = {st_ff.dquo[DW-2:0], 1'b0};
      if (t >= st_ff.dden) begin
        t = t - st_ff.dden;
        q[0] = 1'b1;
      end
      nxt_st.drem = t;
      nxt_st.dquo = q;
      nxt_st.dcnt = st_ff.dcnt - 6'h1;
      if (st_ff.dcnt == 6'h1) begin
        nxt_st.dbusy = 1'b0;
        nxt_st.meas = q > DW'(SPD_FULL) ? SPD_FULL : q[14:0];
        if (32'(nxt_st.meas) * 32'(range) <
            32'(st_ff.w[W_SMIN][15:0]) * 32'(SPD_FULL)) begin
          nxt_st.meas = 15'h0;
        end
      end
    end
    // ramp: one code step each time the ns budget of a step is spent
    if (!en) begin
      nxt_st.ramp = 15'h0;
      nxt_st.racc = 40'h0;
    end else if (rns == 36'h0) begin
      nxt_st.ramp = st_ff.w[W_REQ][14:0];
    end else if (st_ff.ramp != st_ff.w[W_REQ][14:0]) begin
      nxt_st.racc = st_ff.racc + 40'(RAMP_STEP);
      if (nxt_st.racc >= 40'(rns)) begin
        nxt_st.racc = nxt_st.racc - 40'(rns);
        nxt_st.ramp = st_ff.ramp < st_ff.w[W_REQ][14:0] ?
                      st_ff.ramp + 15'h1 : st_ff.ramp - 15'h1;
      end
    end
    // speed loop, run on period boundaries
    if (pstart) begin
      nxt_st.sccnt = sctick ? 8'h0 : st_ff.sccnt + 8'h1;
    end
    if (!en) begin
      nxt_st.integ = 15'h0;
      nxt_st.duty = 15'h0;
    end else if (sctick) begin
      pt = (kp * err) >>> GAIN_FRAC;
      it = $signed({26'h0, st_ff.integ}) + ((ki * err) >>> GAIN_FRAC);
      nxt_st.integ = sat15(it);
      nxt_st.duty = olp ? st_ff.ramp :
        sat15(pt + $signed({26'h0, nxt_st.integ}));
    end
    // sensing window from period start to sample edge
    nxt_st.link = 1'b0;
    if (!st_ff.act && pstart) begin
      nxt_st.act = 1'b1;
      nxt_st.wns = 34'h0;
    end else if (st_ff.act && wend) begin
      nxt_st.act = 1'b0;
      nxt_st.x = xal;
      nxt_st.scnt = st_ff.scnt + 4'h1;
      nxt_st.link = st_ff.scnt == 4'hf;
    end else if (st_ff.act) begin
      nxt_st.wns = st_ff.wns + 34'(CLK_NS);
    end
    nxt_st.trg = nxt_st.act == thi;
    // first order low pass, 1/64 step every time constant / 64
    if (flim == 34'h0) begin
      nxt_st.y = st_ff.x;
    end else if (st_ff.fns + 34'(FILT_STEP) >= flim) begin
      nxt_st.fns = 34'h0;
      nxt_st.y = st_ff.y + 24'(fdif >>> FILT_SH);
    end else begin
      nxt_st.fns = st_ff.fns + 34'(FILT_STEP);
    end
    if (st_ff.link) begin
      nxt_st.vb = st_ff.y;
    end
    // brake decision and output level
    if (over) begin
      bn = 1'b1;
    end else if (under) begin
      bn = 1'b0;
    end else begin
      bn = bsoft ? bcmp : st_ff.bst;
    end
    nxt_st.bst = bn;
    nxt_st.brk = bhi ? bn : !bn;
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // conversion result queue filled by outside transfer logic
  always_ff @(posedge aclk) begin
    if (q_we) begin
      q_mem[q_addr] <= q_wdata;
    end
  end

  // checks on the driven behaviour
  a_no_overlap: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (phase_out & phase_pair_out) == 3'h0)
    else $error("phase and partner driven together");
  a_disabled_quiet: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !$past(en) |-> phase_out == 3'h0 && phase_pair_out == 3'h0)
    else $error("phase outputs active while disabled");
  a_brake_full_on: assert property (
    @(posedge aclk) disable iff (!aresetn)
    over |=> brake_out == $past(bhi))
    else $error("brake not on above upper threshold");
  a_brake_off: assert property (
    @(posedge aclk) disable iff (!aresetn)
    under |=> brake_out != $past(bhi))
    else $error("brake not off below lower threshold");
  a_trig_level: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> adc_trig_out == (st_ff.act == $past(thi)))
    else $error("trigger level does not follow polarity");
  a_window_end: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $fell(st_ff.act) |-> $past(wend))
    else $error("sample window closed early");
  a_sense_sync: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(st_ff.act) |-> $past(pstart))
    else $error("sensing not started at period start");
  a_link_sixteen: assert property (
    @(posedge aclk) disable iff (!aresetn)
    st_ff.link |-> st_ff.scnt == 4'h0 && $past(st_ff.scnt) == 4'hf)
    else $error("brake link not on sixteenth period");
  a_open_duty: assert property (
    @(posedge aclk) disable iff (!aresetn)
    sctick && en && olp |=> st_ff.duty == $past(st_ff.ramp))
    else $error("open loop duty not the ramped speed");
  a_ramp_step: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $past(en) && $past(st_ff.w[W_RAMP][15:0]) != 16'h0 |->
    (st_ff.ramp - $past(st_ff.ramp)) inside {15'h0, 15'h1, 15'h7fff})
    else $error("ramp moved more than one step");
  a_bresp_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
endmodule : bhsb_ctrl

// *** rtl/bhsb_pkg.sv ***
// package: register map, field positions, state and constants of the drive
package bhsb_pkg;
  // clock and time units
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CLK_NS = 25;
  localparam int unsigned NS_PER_US = 1000;
  localparam int unsigned NS_PER_MS = 1_000_000;
  localparam int unsigned PCT = 100;
  // register word indices, byte address is four times the index
  localparam int NCFG = 15;
  localparam int W_CTRL = 0;
  localparam int W_FREQ = 1;
  localparam int W_DEAD = 2;
  localparam int W_SPD = 3;
  localparam int W_SMIN = 4;
  localparam int W_SCDIV = 5;
  localparam int W_KP = 6;
  localparam int W_KI = 7;
  localparam int W_RAMP = 8;
  localparam int W_REQ = 9;
  localparam int W_BTHR = 10;
  localparam int W_NOM = 11;
  localparam int W_SWIN = 12;
  localparam int W_QOFF = 13;
  localparam int W_FILT = 14;
  localparam int W_STAT = 15;
  localparam int W_BUSV = 16;
  localparam int W_DUTY = 17;
  // control word bits
  localparam int C_EN = 0;
  localparam int C_OPEN = 1;
  localparam int C_CPL = 2;
  localparam int C_SEC = 3;
  localparam int C_BSOFT = 4;
  localparam int C_BHI = 5;
  localparam int C_THI = 6;
  localparam int C_SH = 8;
  // speed scale, unity gain is 1 << GAIN_FRAC in signed 9.15
  localparam logic [14:0] SPD_FULL = 15'h7fff;
  localparam int GAIN_FRAC = 15;
  localparam int DW = 52;
  localparam logic [DW-1:0] SPD_NUM = DW'(64'd60 * CLK_HZ * SPD_FULL);
  localparam logic [19:0] RAMP_STEP = 20'(CLK_NS * SPD_FULL);
  localparam int FILT_SH = 6;
  localparam logic [15:0] FILT_STEP = 16'(CLK_NS << FILT_SH);
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [NCFG-1:0][31:0] w;
    logic aw_ok;
    logic w_ok;
    logic [5:0] awi;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [25:0] acc;
    logic raw;
    logic [16:0] dns;
    logic [7:0] sccnt;
    logic [2:0] hprev;
    logic [2:0] sec;
    logic [23:0] hcnt;
    logic [4:0][23:0] hist;
    logic dbusy;
    logic [5:0] dcnt;
    logic [DW-1:0] drem;
    logic [DW-1:0] dquo;
    logic [DW-1:0] dden;
    logic [14:0] meas;
    logic [14:0] ramp;
    logic [39:0] racc;
    logic [14:0] integ;
    logic [14:0] duty;
    logic act;
    logic [33:0] wns;
    logic [3:0] scnt;
    logic link;
    logic [23:0] x;
    logic [23:0] y;
    logic [33:0] fns;
    logic [23:0] vb;
    logic bst;
    logic [2:0] ph;
    logic [2:0] pr;
    logic brk;
    logic trg;
  } bhsb_state_t;
endpackage : bhsb_pkg

// *** tb/bhsb_motor_model.sv ***
// bhsb_motor_model: hall sensors and a/d result transfer of the far side
`timescale 1ns/1ps
module bhsb_motor_model (
  input wire logic aclk,
  input wire logic spin,
  input wire logic [2:0] hold,
  input wire logic [15:0] per,
  input wire logic [15:0] smp,
  output logic [2:0] hall_in,
  output logic q_we,
  output logic [2:0] q_addr,
  output logic [15:0] q_wdata
);
  logic [2:0] seq [6] = '{3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h5};
  int pos = 0;
  int cnt = 0;
  initial begin
    hall_in = 3'h0;
    q_we = 1'b0;
    q_addr = 3'h0;
    q_wdata = 16'h0;
  end
  // hall pattern advances one sector every per cycles while spinning
  always @(posedge aclk) begin
    cnt <= (cnt + 1 >= per) ? 0 : cnt + 1;
    if (spin && cnt + 1 >= per) pos <= (pos + 1) % 6;
    hall_in <= spin ? seq[pos] : hold;
  end
  // one word refreshed per cycle; only word two holds the bus sample
  always @(posedge aclk) begin
    q_we <= 1'b1;
    q_addr <= q_addr + 3'h1;
    q_wdata <= (q_addr + 3'h1 == 3'h2) ? smp : ~smp;
  end
endmodule : bhsb_motor_model

// *** tb/test_bldc_hall_speed_brake_ctrl.sv ***
// test_bldc_hall_speed_brake_ctrl: self-checking bench of the drive block
`timescale 1ns/1ps
module test_bldc_hall_speed_brake_ctrl;
  import bhsb_pkg::*;
  typedef struct packed {
    logic [1:0] r;
    logic [31:0] d;
    logic [31:0] m;
  } bhsb_exp_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, rnd = 32'h66a5;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, brk, trg, spin = 1'b0;
  logic [1:0] bresp, rresp;
  logic [2:0] ph, pr, hall, q_addr, hold = 3'h0;
  logic q_we;
  logic [15:0] q_wdata, per = 16'd2500, smp = 16'h0;
  bhsb_exp_t q[$];
  bhsb_exp_t e;
  int err_count = 0, samples_checked = 0, cyc = 0;
  int cnt[9];
  int shb[4] = '{8, 10, 12, 16};
  int ci[13] = '{W_FREQ, W_DEAD, W_SPD, W_SMIN, W_SCDIV, W_KP, W_RAMP,
    W_REQ, W_BTHR, W_NOM, W_SWIN, W_QOFF, W_FILT};
  logic [31:0] cv[13] = '{32'd400000, 32'd100, 32'h0008ce2f, 32'h0, 32'h1,
    32'h8000, 32'h0, 32'h4000, 32'h6e82, 32'h100000, 32'h1, 32'h4, 32'h0};

  bhsb_ctrl #(.QDEPTH(8)) dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .hall_in(hall), .q_we(q_we), .q_addr(q_addr),
    .q_wdata(q_wdata), .phase_out(ph), .phase_pair_out(pr),
    .brake_out(brk), .adc_trig_out(trg));
  bhsb_motor_model model_u (.aclk(aclk), .spin(spin), .hold(hold),
    .per(per), .smp(smp), .hall_in(hall), .q_we(q_we), .q_addr(q_addr),
    .q_wdata(q_wdata));

  // 40 mhz clock
  initial forever #12.5 aclk = ~aclk;

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  function automatic logic [31:0] in_rng(input int v, input int lo, hi);
    return 32'(v >= lo && v <= hi);
  endfunction : in_rng

  task automatic check(input logic [31:0] s, x, input string msg);
    samples_checked++;
    if (s !== x) begin
      err_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, s,
        x);
    end
  endtask : check

  task automatic complete_run;
    if (err_count == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run

  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask : idle

  // write: address and data offered together, held until each is taken
  task automatic wr(input int i, input logic [31:0] d,
      input logic [3:0] s = 4'hf, input logic [1:0] r = RESP_OKAY);
    q.push_back('{r, 32'h0, 32'h0});
    @(posedge aclk);
    awaddr <= 8'(i * 4);
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // the write response ends this wait, or the hang guard if none comes
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input int i, input logic [31:0] d,
      input logic [31:0] m = 32'hffffffff, input logic [1:0] r = RESP_OKAY);
    q.push_back('{r, d, m});
    @(posedge aclk);
    araddr <= 8'(i * 4);
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask : rd

  // counts pin activity over n settled cycles
  task automatic watch(input int n);
    logic pa;
    cnt = '{default: 0};
    pa = ph[0];
    repeat (n) begin
      @(negedge aclk);
      cnt[0] += ph[0];
      cnt[1] += pr[0];
      cnt[2] += ph[0] & pr[0];
      cnt[3] += !ph[0] & !pr[0];
      cnt[4] += pr[1];
      cnt[5] += ph[2] | pr[2];
      cnt[6] += ph[0] & !pa;
      cnt[7] += brk;
      cnt[8] += trg;
      pa = ph[0];
    end
  endtask : watch

  // bus answers are matched against the oldest noted expectation
  always @(posedge aclk) begin
    if ((bvalid && bready) || (rvalid && rready)) begin
      e = q.pop_front();
      if (bvalid) check({30'h0, bresp}, {30'h0, e.r}, "write response");
      else begin
        check({30'h0, rresp}, {30'h0, e.r}, "read response");
        check(rdata & e.m, e.d & e.m, "read data");
      end
    end
  end

  // hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_count++;
      complete_run();
    end
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(W_CTRL, 32'h0);
    rd(W_STAT, 32'h0, 32'h7fff0100);
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      wr(W_KP + k, rnd);
      rd(W_KP + k, rnd);
    end
    rd(18, 32'h0, 32'h0, RESP_SLVERR);
    wr(18, 32'h5a5a5a5a, 4'hf, RESP_SLVERR);
    wr(W_STAT, 32'hffffffff);
    rd(W_STAT, 32'h0, 32'h7fff0100);
    wr(W_QOFF, 32'h0);
    wr(W_QOFF, 32'hffffffff, 4'h1);
    rd(W_QOFF, 32'hff);
    for (int k = 0; k < 13; k++) wr(ci[k], cv[k]);
    smp <= 16'h0123;
    for (int k = 0; k < 4; k++) begin
      wr(W_CTRL, 32'(k) << C_SH);
      idle(800);
      rd(W_BUSV, 32'(24'(32'h0123 << shb[k])));
    end
    smp <= 16'h1000;
    wr(W_CTRL, 32'h0);
    idle(2000);
    check({31'h0, brk}, 32'h1, "brake low bus");
    smp <= 16'h1800;
    idle(2000);
    check({31'h0, brk}, 32'h0, "brake high bus");
    wr(W_CTRL, 32'h1 << C_BHI);
    idle(20);
    check({31'h0, brk}, 32'h1, "brake polarity");
    smp <= 16'h1000;
    idle(2000);
    check({31'h0, brk}, 32'h0, "brake released");
    wr(W_CTRL, 32'h1 << C_BHI | 32'h1 << C_BSOFT | 32'h1 << C_THI);
    smp <= 16'h1333;
    idle(2000);
    watch(400);
    check(in_rng(cnt[7], 140, 260), 32'h1, "soft brake duty");
    check(in_rng(cnt[8], 140, 190), 32'h1, "trigger high");
    hold <= 3'h4;
    wr(W_CTRL, 32'h3);
    idle(400);
    rd(W_DUTY, 32'h4000);
    watch(400);
    check(32'(cnt[1] + cnt[4]), 32'h0, "single pair");
    check(in_rng(cnt[6], 3, 5), 32'h1, "pwm periods");
    check(in_rng(cnt[0], 150, 250), 32'h1, "phase duty");
    check(32'(cnt[5]), 32'h0, "idle phase");
    check(in_rng(cnt[8], 210, 260), 32'h1, "trigger low");
    wr(W_CTRL, 32'h7);
    idle(200);
    watch(400);
    check(32'(cnt[2]), 32'h0, "pair overlap");
    check(32'(cnt[4]), 32'd400, "low side pair");
    check(32'(cnt[0] + cnt[1] + cnt[3]), 32'd400, "pair cover");
    check(in_rng(cnt[3], 24, 40), 32'h1, "dead time");
    wr(W_CTRL, 32'h0);
    idle(5);
    watch(100);
    check(32'(cnt[0] + cnt[1] + cnt[4] + cnt[5]), 32'h0, "off");
    rd(W_DUTY, 32'h0);
    spin <= 1'b1;
    wr(W_CTRL, 32'h1 << C_SEC | 32'h3);
    idle(20000);
    rd(W_STAT, 32'h30000100, 32'h7f000100);
    wr(W_CTRL, 32'h3);
    idle(20000);
    rd(W_STAT, 32'h30000100, 32'h7f000100);
    wr(W_SMIN, 32'd30000);
    idle(6000);
    rd(W_STAT, 32'h100, 32'h7fff0100);
    // closed loop with measured speed held at zero: error is the request
    wr(W_CTRL, 32'h0);
    wr(W_KI, 32'h0);
    wr(W_KP, 32'h4000);
    wr(W_CTRL, 32'h1);
    idle(400);
    rd(W_DUTY, 32'h2000);
    wr(W_KP, 32'h0);
    wr(W_KI, 32'h8000);
    idle(400);
    rd(W_DUTY, 32'h7fff);
    // 1 ms ramp: about 3277 codes after 100 us
    wr(W_CTRL, 32'h0);
    wr(W_RAMP, 32'h1);
    wr(W_CTRL, 32'h3);
    idle(4000);
    rd(W_DUTY, 32'h0c00, 32'h7f00);
    complete_run();
  end
endmodule : test_bldc_hall_speed_brake_ctrl
